/* reset_and_alarm_pin_logic_pkg.sv */
// Register map, field layout and timing constants of the reset and alarm pin logic
package reset_and_alarm_pin_logic_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned CHANNELS      = 4;
    localparam int unsigned ADDR_LSB_BITS = 2;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CHAN_CFG = 8'h00;
    localparam logic [7:0] OFS_CTRL     = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // ------------------------------------------------------------------
    // Channel configuration field layout, one byte per channel
    // ------------------------------------------------------------------
    localparam int unsigned CFG_STRIDE    = 8;
    localparam int unsigned CFG_ALARM_EN  = 0;
    localparam int unsigned CFG_ALARM_POL = 1;
    localparam int unsigned CFG_FAULT_POL = 2;
    localparam int unsigned CFG_CLK_EN    = 3;
    localparam int unsigned CFG_PIN_MASK  = 4;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK     = 32'h1f1f_1f1f;

    // ------------------------------------------------------------------
    // Control, status and interrupt field layout
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SOFT_RST = 0;
    localparam int unsigned CTRL_CAL_LSB  = 4;
    localparam int unsigned STAT_FAULT    = 0;
    localparam int unsigned STAT_LOCK     = 4;
    localparam int unsigned STAT_BUSY     = 8;
    localparam int unsigned STAT_SOFT     = 12;
    localparam int unsigned IRQ_LOSS_LSB  = 0;
    localparam int unsigned IRQ_CAL_LSB   = 4;
    localparam logic [7:0]  IRQ_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ      = 100;
    localparam int unsigned SOFT_RESET_TIME_MS = 10;
    localparam int unsigned SOFT_RESET_CYCLES = SOFT_RESET_TIME_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned SOFT_CNT_BITS     = 20;

    // ------------------------------------------------------------------
    // AHB encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage : reset_and_alarm_pin_logic_pkg

/* reset_release_sync.sv */
// Reset synchroniser: asynchronous assertion, release on a clock edge
`timescale 1ns/1ps
module reset_release_sync (
    input  wire logic hclk,
    input  wire logic raw_rst_n,
    output logic      sync_rst_n
);

    logic stage1_reg;
    logic stage2_reg;

    // Two flops so every channel leaves reset on one common edge
    always_ff @(posedge hclk or negedge raw_rst_n) begin
        if (!raw_rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_rst_n = stage2_reg;

    // Release only after two clean edges of the raw reset being high
    property p_release_two_edges;
        @(posedge hclk) disable iff (!raw_rst_n)
        $rose(sync_rst_n) |-> $past(stage1_reg) && !$past(sync_rst_n);
    endproperty
    a_release_two_edges: assert property (p_release_two_edges)
        else $error("reset released without two synchroniser edges");

endmodule : reset_release_sync

/* alarm_pin_channel.sv */
// One channel's alarm pin: fault sense, mask, polarity and tristate
`timescale 1ns/1ps
module alarm_pin_channel (
    input  wire logic hclk,
    input  wire logic rst_n,
    input  wire logic alarm_output_enable,
    input  wire logic alarm_polarity,
    input  wire logic input_fault_polarity,
    input  wire logic pin_mask,
    input  wire logic input_signal_missing,
    output logic      alarm_out,
    output logic      alarm_oe,
    output logic      fault
);

    logic fault_next;
    logic alarm_out_next;

    // Raw monitor sense flipped by the fault polarity, then masked and polarised
    always_comb begin
        fault_next     = input_signal_missing ^ input_fault_polarity;
        alarm_out_next = (fault_next & ~pin_mask) ^ alarm_polarity;
    end

    // Pin is driven only while its alarm function is enabled
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_oe <= 1'b0;
        end else begin
            alarm_oe <= alarm_output_enable;
        end
    end

    // Level and fault flag registered so the pin never glitches
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_out <= 1'b0;
            fault     <= 1'b0;
        end else begin
            alarm_out <= alarm_out_next;
            fault     <= fault_next;
        end
    end

    property p_tristate_when_off;
        @(posedge hclk) disable iff (!rst_n)
        !alarm_output_enable ##1 !alarm_output_enable |-> !alarm_oe;
    endproperty
    a_tristate_when_off: assert property (p_tristate_when_off)
        else $error("alarm pin driven with no alarm function selected");

    property p_drive_when_on;
        @(posedge hclk) disable iff (!rst_n)
        alarm_output_enable |=> alarm_oe;
    endproperty
    a_drive_when_on: assert property (p_drive_when_on)
        else $error("enabled alarm pin not driven");

    property p_loss_shows_one;
        @(posedge hclk) disable iff (!rst_n)
        (input_signal_missing && !input_fault_polarity && !pin_mask && !alarm_polarity)
            |=> alarm_out && fault;
    endproperty
    a_loss_shows_one: assert property (p_loss_shows_one)
        else $error("signal loss did not show as one on the alarm pin");

    property p_mask_holds_idle;
        @(posedge hclk) disable iff (!rst_n)
        pin_mask |=> alarm_out == $past(alarm_polarity);
    endproperty
    a_mask_holds_idle: assert property (p_mask_holds_idle)
        else $error("masked alarm pin left its idle level");

endmodule : alarm_pin_channel

/* reset_and_alarm_pin_logic.sv */
// Reset handling, alarm pins, calibration start and AHB-Lite registers
`timescale 1ns/1ps
// What this block does
// - Pin reset resets all four channels together
// - Reset restores every configuration register default
// - Clock outputs tristated while reset holds
// - Alarm pin drives only when enabled
// - Alarm maskable, active level follows polarity
// - Alarm shows one on input signal loss
// - Unselected alarm pin left high impedance
// - Calibration start self-clears, done when lock_lost low
module reset_and_alarm_pin_logic #(
    parameter int unsigned CHANNELS          = reset_and_alarm_pin_logic_pkg::CHANNELS,
    parameter int unsigned SOFT_RESET_CYCLES = reset_and_alarm_pin_logic_pkg::SOFT_RESET_CYCLES
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                hardware_reset_n,
    input  wire logic [CHANNELS-1:0] input_signal_missing,
    input  wire logic [CHANNELS-1:0] lock_lost_alarm,
    output logic [CHANNELS-1:0]      alarm_out,
    output logic [CHANNELS-1:0]      alarm_oe,
    output logic [CHANNELS-1:0]      clock_out_oe,
    output logic [CHANNELS-1:0]      calibration_start,
    output logic                     channel_rst_n,
    output logic                     irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W = reset_and_alarm_pin_logic_pkg::SOFT_CNT_BITS;
    localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SOFT_RESET_CYCLES - 1);

    logic                raw_rst_n;
    logic                int_rst_n;
    logic                soft_hold_reg;
    logic [CNT_W-1:0]    soft_cnt_reg;
    logic                wr_pend_reg;
    logic [7:0]          wr_addr_reg;
    logic                addr_ok;
    logic [7:0]          addr_ofs;
    logic [31:0]         rd_next;
    logic [31:0]         chan_cfg_reg;
    logic [7:0]          irq_stat_reg;
    logic [7:0]          irq_stat_next;
    logic [7:0]          irq_mask_reg;
    logic [7:0]          irq_set;
    logic [7:0]          irq_clr;
    logic [CHANNELS-1:0] cal_busy_reg;
    logic [CHANNELS-1:0] fault;
    logic [CHANNELS-1:0] fault_seen_reg;
    logic [CHANNELS-1:0] cal_req;
    logic                wr_cfg;
    logic                wr_ctrl;
    logic                wr_istat;
    logic                wr_imask;

    // ------------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------------
    // Pin reset, bus reset and soft reset all funnel into one reset
    assign raw_rst_n = hresetn & hardware_reset_n & ~soft_hold_reg;

    reset_release_sync u_rst_sync (
        .hclk       (hclk),
        .raw_rst_n  (raw_rst_n),
        .sync_rst_n (int_rst_n)
    );

    assign channel_rst_n = int_rst_n;

    // Soft reset timer lives on the bus reset only, so it is not cleared by itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_hold_reg <= 1'b0;
            soft_cnt_reg  <= '0;
        end else if (soft_hold_reg) begin
            if (soft_cnt_reg == SOFT_LAST) begin
                soft_hold_reg <= 1'b0;
                soft_cnt_reg  <= '0;
            end else begin
                soft_cnt_reg  <= soft_cnt_reg + CNT_W'(1);
            end
        end else if (wr_ctrl && hwdata[reset_and_alarm_pin_logic_pkg::CTRL_SOFT_RST]) begin
            soft_hold_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    // Zero wait states; every transfer answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = reset_and_alarm_pin_logic_pkg::HRESP_OKAY;
    assign addr_ofs  = haddr[7:0];
    assign addr_ok   = hsel && hready && (htrans == reset_and_alarm_pin_logic_pkg::HTRANS_NONSEQ)
                       && (haddr[31:8] == 24'h00_0000);

    // Write address captured in address phase, data applied in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= addr_ofs;
        end
    end

    assign wr_cfg   = wr_pend_reg && (wr_addr_reg == reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG);
    assign wr_ctrl  = wr_pend_reg && (wr_addr_reg == reset_and_alarm_pin_logic_pkg::OFS_CTRL);
    assign wr_istat = wr_pend_reg && (wr_addr_reg == reset_and_alarm_pin_logic_pkg::OFS_IRQ_STAT);
    assign wr_imask = wr_pend_reg && (wr_addr_reg == reset_and_alarm_pin_logic_pkg::OFS_IRQ_MASK);

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (addr_ofs)
            reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG: rd_next = chan_cfg_reg;
            reset_and_alarm_pin_logic_pkg::OFS_CTRL: begin
                rd_next[reset_and_alarm_pin_logic_pkg::CTRL_SOFT_RST] = soft_hold_reg;
            end
            reset_and_alarm_pin_logic_pkg::OFS_STATUS: begin
                rd_next[reset_and_alarm_pin_logic_pkg::STAT_FAULT +: CHANNELS] = fault;
                rd_next[reset_and_alarm_pin_logic_pkg::STAT_LOCK +: CHANNELS]  = lock_lost_alarm;
                rd_next[reset_and_alarm_pin_logic_pkg::STAT_BUSY +: CHANNELS]  = cal_busy_reg;
                rd_next[reset_and_alarm_pin_logic_pkg::STAT_SOFT]              = soft_hold_reg;
            end
            reset_and_alarm_pin_logic_pkg::OFS_IRQ_STAT: rd_next[7:0] = irq_stat_reg;
            reset_and_alarm_pin_logic_pkg::OFS_IRQ_MASK: rd_next[7:0] = irq_mask_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase edge, valid in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    // ------------------------------------------------------------------
    // Channel configuration
    // ------------------------------------------------------------------
    // Cleared by every reset source so the host must reprogram
    always_ff @(posedge hclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            chan_cfg_reg <= reset_and_alarm_pin_logic_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            chan_cfg_reg <= hwdata & reset_and_alarm_pin_logic_pkg::CFG_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            localparam int unsigned B = c * reset_and_alarm_pin_logic_pkg::CFG_STRIDE;

            alarm_pin_channel u_alarm (
                .hclk                 (hclk),
                .rst_n                (int_rst_n),
                .alarm_output_enable  (chan_cfg_reg[B + reset_and_alarm_pin_logic_pkg::CFG_ALARM_EN]),
                .alarm_polarity       (chan_cfg_reg[B + reset_and_alarm_pin_logic_pkg::CFG_ALARM_POL]),
                .input_fault_polarity (chan_cfg_reg[B + reset_and_alarm_pin_logic_pkg::CFG_FAULT_POL]),
                .pin_mask             (chan_cfg_reg[B + reset_and_alarm_pin_logic_pkg::CFG_PIN_MASK]),
                .input_signal_missing (input_signal_missing[c]),
                .alarm_out            (alarm_out[c]),
                .alarm_oe             (alarm_oe[c]),
                .fault                (fault[c])
            );

            // Outputs stay tristated until the host sets the clock enable
            always_ff @(posedge hclk or negedge int_rst_n) begin
                if (!int_rst_n) begin
                    clock_out_oe[c] <= 1'b0;
                end else begin
                    clock_out_oe[c] <= chan_cfg_reg[B + reset_and_alarm_pin_logic_pkg::CFG_CLK_EN];
                end
            end

            assign cal_req[c] = wr_ctrl && hwdata[reset_and_alarm_pin_logic_pkg::CTRL_CAL_LSB + c];

            // Self-clearing start pulse; busy until lock_lost_alarm falls
            always_ff @(posedge hclk or negedge int_rst_n) begin
                if (!int_rst_n) begin
                    calibration_start[c] <= 1'b0;
                    cal_busy_reg[c]      <= 1'b0;
                end else begin
                    calibration_start[c] <= cal_req[c];
                    if (cal_req[c]) begin
                        cal_busy_reg[c] <= 1'b1;
                    end else if (cal_busy_reg[c] && !calibration_start[c] && !lock_lost_alarm[c]) begin
                        cal_busy_reg[c] <= 1'b0;
                    end
                end
            end

            // Event sources: rising fault, calibration completion
            assign irq_set[reset_and_alarm_pin_logic_pkg::IRQ_LOSS_LSB + c] = fault[c] & ~fault_seen_reg[c];
            assign irq_set[reset_and_alarm_pin_logic_pkg::IRQ_CAL_LSB + c]  =
                cal_busy_reg[c] & ~cal_req[c] & ~calibration_start[c] & ~lock_lost_alarm[c];
        end
    endgenerate

    // Previous fault level for edge detection
    always_ff @(posedge hclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            fault_seen_reg <= '0;
        end else begin
            fault_seen_reg <= fault;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // Write one to clear; a set in the same cycle wins over the clear
    assign irq_clr       = wr_istat ? hwdata[7:0] : 8'h00;
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

    always_ff @(posedge hclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            irq_stat_reg <= reset_and_alarm_pin_logic_pkg::IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always_ff @(posedge hclk or negedge int_rst_n) begin
        if (!int_rst_n) begin
            irq_mask_reg <= reset_and_alarm_pin_logic_pkg::IRQ_RESET;
        end else if (wr_imask) begin
            irq_mask_reg <= hwdata[7:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_outputs_off_in_reset;
        @(posedge hclk) disable iff (!hresetn)
        !int_rst_n |-> (clock_out_oe == '0) && (alarm_oe == '0);
    endproperty
    a_outputs_off_in_reset: assert property (p_outputs_off_in_reset)
        else $error("outputs driven while in reset");

    property p_defaults_after_reset;
        @(posedge hclk) disable iff (!hresetn)
        $rose(int_rst_n) |-> chan_cfg_reg == reset_and_alarm_pin_logic_pkg::CFG_RESET;
    endproperty
    a_defaults_after_reset: assert property (p_defaults_after_reset)
        else $error("configuration not at default after reset");

    property p_pin_reset_all;
        @(posedge hclk) disable iff (!hresetn)
        !hardware_reset_n ##1 !hardware_reset_n |-> !channel_rst_n && (calibration_start == '0);
    endproperty
    a_pin_reset_all: assert property (p_pin_reset_all)
        else $error("pin reset did not hold every channel");

    property p_clock_needs_config;
        @(posedge hclk) disable iff (!int_rst_n)
        $rose(clock_out_oe[0]) |-> $past(wr_cfg, 2);
    endproperty
    a_clock_needs_config: assert property (p_clock_needs_config)
        else $error("clock output appeared without configuration");

    property p_cal_self_clears;
        @(posedge hclk) disable iff (!int_rst_n)
        (wr_ctrl && hwdata[reset_and_alarm_pin_logic_pkg::CTRL_CAL_LSB]) ##1 !cal_req[0]
            |-> calibration_start[0] && cal_busy_reg[0] ##1 !calibration_start[0];
    endproperty
    a_cal_self_clears: assert property (p_cal_self_clears)
        else $error("calibration start did not pulse for one cycle");

    property p_irq_gated;
        @(posedge hclk) disable iff (!int_rst_n)
        $rose(irq) |-> ((($past(irq_set) & $past(irq_mask_reg)) != 8'h00) || $past(wr_imask));
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt rose with no unmasked event");

endmodule : reset_and_alarm_pin_logic

/* alarm_far_side.sv */
// Far-side model: host reset pin, channel monitors and lock indicators
`timescale 1ns/1ps
module alarm_far_side #(
    parameter int unsigned LOCK_DELAY = 8
) (
    input  wire logic       hclk,
    input  wire logic       rst_cmd,
    input  wire logic [3:0] loss_cmd,
    input  wire logic [3:0] calibration_start,
    output logic            hardware_reset_n,
    output logic [3:0]      input_signal_missing,
    output logic [3:0]      lock_lost_alarm
);
    int unsigned wait_cnt;
    // Lines start idle so the first reset release is clean
    initial begin
        hardware_reset_n = 1'b1;
        input_signal_missing = 4'h0;
        lock_lost_alarm = 4'h0;
        wait_cnt = 0;
    end
    // Lock drops on calibration start and returns late, to stall the host
    always @(posedge hclk) begin
        hardware_reset_n <= rst_cmd;
        input_signal_missing <= loss_cmd;
        if (calibration_start != 4'h0) begin
            lock_lost_alarm <= lock_lost_alarm | calibration_start;
            wait_cnt <= LOCK_DELAY;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else begin
            lock_lost_alarm <= 4'h0;
        end
    end
endmodule : alarm_far_side

/* reset_and_alarm_pin_logic_test.sv */
// Self-checking bench for the reset and alarm pin logic
`timescale 1ns/1ps
module reset_and_alarm_pin_logic_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, rst_cmd = 1'b1, channel_rst_n, irq, pin_rst_n;
    logic [31:0] hrdata;
    logic [3:0]  loss_cmd = 4'h0, missing, lock_lost, alarm_out, alarm_oe, clock_out_oe, cal;
    int          fail_count = 0;
    int          checks_done = 0;
    always #5 hclk = ~hclk;
    reset_and_alarm_pin_logic #(.SOFT_RESET_CYCLES(16)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .hardware_reset_n(pin_rst_n), .input_signal_missing(missing),
        .lock_lost_alarm(lock_lost), .alarm_out(alarm_out), .alarm_oe(alarm_oe),
        .clock_out_oe(clock_out_oe), .calibration_start(cal),
        .channel_rst_n(channel_rst_n), .irq(irq));
    alarm_far_side far (.hclk(hclk), .rst_cmd(rst_cmd), .loss_cmd(loss_cmd),
        .calibration_start(cal), .hardware_reset_n(pin_rst_n),
        .input_signal_missing(missing), .lock_lost_alarm(lock_lost));
    // Compare and count; unknowns never match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One single AHB-Lite transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #20us;
        fail_count++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        rd(reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG, 32'h0);
        rd(reset_and_alarm_pin_logic_pkg::OFS_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        chk(clock_out_oe, 4'h0);
        chk(alarm_oe, 4'h0);
        // ch0 plain, ch1 active low, ch2 inverted sense, ch3 masked and unselected
        wr(reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG, 32'h180d0b09);
        wr(reset_and_alarm_pin_logic_pkg::OFS_IRQ_MASK, 32'h01);
        repeat (2) @(posedge hclk);
        chk(clock_out_oe, 4'hf);
        chk(alarm_oe, 4'h7);
        chk(alarm_out, 4'h6);
        chk(irq, 1'b0);
        loss_cmd <= 4'hf;
        repeat (5) @(posedge hclk);
        chk(alarm_out, 4'h1);
        chk(irq, 1'b1);
        rd(reset_and_alarm_pin_logic_pkg::OFS_IRQ_STAT, 32'h0f);
        rd(reset_and_alarm_pin_logic_pkg::OFS_STATUS, 32'h0b);
        wr(reset_and_alarm_pin_logic_pkg::OFS_IRQ_STAT, 32'h0f);
        @(negedge hclk);
        chk(irq, 1'b0);
        // Calibration: pulse, lock lost by the far side, then done flag
        wr(reset_and_alarm_pin_logic_pkg::OFS_CTRL, 32'h10);
        #1;
        chk(cal, 4'h1);
        @(posedge hclk);
        #1;
        chk(cal, 4'h0);
        repeat (20) @(posedge hclk);
        rd(reset_and_alarm_pin_logic_pkg::OFS_IRQ_STAT, 32'h10);
        // Pin reset in mid-run clears channels, outputs and settings
        rst_cmd <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(channel_rst_n, 1'b0);
        chk(clock_out_oe, 4'h0);
        chk(alarm_oe, 4'h0);
        rst_cmd <= 1'b1;
        repeat (5) @(posedge hclk);
        chk(channel_rst_n, 1'b1);
        rd(reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG, 32'h0);
        // Soft reset acts like the pin; host waits out the hold
        wr(reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG, 32'h08);
        wr(reset_and_alarm_pin_logic_pkg::OFS_CTRL, 32'h01);
        repeat (4) @(posedge hclk);
        chk(clock_out_oe, 4'h0);
        rd(reset_and_alarm_pin_logic_pkg::OFS_CTRL, 32'h1);
        repeat (30) @(posedge hclk);
        rd(reset_and_alarm_pin_logic_pkg::OFS_CHAN_CFG, 32'h0);
        test_done();
    end
endmodule : reset_and_alarm_pin_logic_test
